// ---- hw/amc_defines.svh ----
// Purpose: Constants for the actuator motion controller
// Assumes: 10 MHz CLK
// Notes:   Times kept in their own unit, cycle counts derived
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH
`define AMC_CLK_HZ          10000000
`define AMC_SLEEP_S         15
`define AMC_SLEEP_CYC       (`AMC_SLEEP_S * `AMC_CLK_HZ)
`define AMC_PROG_S          5
`define AMC_PROG_CYC        (`AMC_PROG_S * `AMC_CLK_HZ)
`define AMC_POS_W           16
// Follower start band in counts, above the steps still in flight
`define AMC_FOLLOW_DB       17'h0_0004
`define AMC_ADC_W           12
// Follower thresholds in ADC codes, 5 V full scale, 12 bits
`define AMC_ADC_LO          12'h19a
`define AMC_ADC_HI          12'he66
`define AMC_ADC_SPAN        12'hccc
`define AMC_POS_MAX_RST     16'hffff
`define AMC_POS_MIN_RST     16'h0000
// Position counts per emitted output pulse
`define AMC_PULSE_DIV_RST   8'h01
// APB map
`define AMC_ADDR_CTRL       12'h000
`define AMC_ADDR_STATUS     12'h004
`define AMC_ADDR_POS        12'h008
`define AMC_ADDR_LIMITS     12'h00c
`define AMC_ADDR_FOLLOW     12'h010
`define AMC_ADDR_STROKE     12'h014
`define AMC_CTRL_RST        32'h0000_0101
`endif

// ---- hw/amc_pkg.sv ----
// Purpose: Types for the actuator motion controller
// Assumes: amc_defines.svh
// Notes:   Types only; numbers live in the defines header
package amc_pkg;
   typedef enum logic [1:0]
   {
      AMC_ST_RUN   = 2'b00,
      AMC_ST_BRAKE = 2'b01,
      AMC_ST_SLEEP = 2'b10
   } amc_state_e;

   typedef struct packed
   {
      logic fwd;
      logic rev;
      logic brake;
      logic sleep;
   } amc_drive_s;

   typedef struct packed
   {
      logic [15:0] ext_lim;
      logic [15:0] ret_lim;
   } amc_limits_s;
endpackage

// ---- hw/amc_top.sv ----
// Purpose: Motion logic of a low-current-input linear actuator
// Assumes: Position counter in the device tracks encoder steps; follower
//          voltage arrives as a sampled 12-bit code from the same clock
// Notes:   APB slave for control and status; no interrupt, no buffer
`timescale 1ns/1ns
`include "amc_defines.svh"
module amc_top
#(
   parameter int unsigned SLEEP_CYC = `AMC_SLEEP_CYC,
   parameter int unsigned PROG_CYC  = `AMC_PROG_CYC
)
(
   input  wire logic                  CLK,
   input  wire logic                  RSTN,
   input  wire logic                  EXTEND_IN,
   input  wire logic                  RETRACT_IN,
   input  wire logic                  PROG_EXT_IN,
   input  wire logic                  PROG_RET_IN,
   input  wire logic [`AMC_ADC_W-1:0] FOLLOW_CODE,
   input  wire logic                  FOLLOW_VALID,
   input  wire logic                  POS_STEP,
   input  wire logic                  POS_DIR_EXT,
   output amc_pkg::amc_drive_s        DRIVE,
   output logic                       MIN_STROKE_CLOSED,
   output logic                       MAX_STROKE_CLOSED,
   output logic                       PULSE_OUT,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [11:0]           PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic [31:0]                PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR
);
   import amc_pkg::*;

   logic [5:0]  sync1_ff, sync2_ff;
   logic [5:0]  nxt_sync1;
   logic        ext_s, ret_s, pext_s, pret_s, step_s, dir_s;
   logic        cmd_ext, cmd_ret, cmd_any, cmd_both;
   logic        follow_en, stationary, follow_extreme;

   amc_state_e  state_ff, nxt_state;
   logic [31:0] idle_ff, nxt_idle;
   logic [31:0] hold_ff, nxt_hold;
   logic [1:0]  hold_key_ff, nxt_hold_key;
   logic        hold_done_ff, nxt_hold_done;
   logic [`AMC_POS_W-1:0] pos_ff, nxt_pos;
   logic [`AMC_POS_W-1:0] stroke_ff, nxt_stroke;
   amc_limits_s lim_ff, nxt_lim;
   logic        lim_set_ff, nxt_lim_set;
   logic [`AMC_POS_W-1:0] target_ff, nxt_target;
   logic [7:0]  div_ff, nxt_div;
   logic [7:0]  pcnt_ff, nxt_pcnt;
   logic        pulse_ff, nxt_pulse;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        err_ff, nxt_err;
   amc_drive_s  drv_ff, nxt_drv;
   logic        min_ff, nxt_min, max_ff, nxt_max;

   logic [`AMC_POS_W-1:0] lo_bound, hi_bound, span, follow_tgt;
   logic [`AMC_ADC_W-1:0] fcode_off;
   logic [`AMC_POS_W+`AMC_ADC_W-1:0] prod;
   logic        want_ext, want_ret;
   logic        apb_wr, apb_rd;

   // Pins are asynchronous to CLK
   assign nxt_sync1 = {POS_DIR_EXT, POS_STEP, PROG_RET_IN, PROG_EXT_IN,
                       RETRACT_IN, EXTEND_IN};
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
      end
      else
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= sync1_ff;
      end
   end
   assign {dir_s, step_s, pret_s, pext_s, ret_s, ext_s} = sync2_ff;

   assign follow_en  = ctrl_ff[0];
   assign cmd_both   = ext_s & ret_s;
   assign cmd_ext    = ext_s & ~ret_s;
   assign cmd_ret    = ret_s & ~ext_s;
   assign cmd_any    = ext_s | ret_s;
   assign stationary = ~drv_ff.fwd & ~drv_ff.rev;
   assign follow_extreme = (FOLLOW_CODE < `AMC_ADC_LO) ||
                           (FOLLOW_CODE > `AMC_ADC_HI);

   // Active stroke is the programmed window if one exists
   assign lo_bound = lim_set_ff ? lim_ff.ret_lim : `AMC_POS_MIN_RST;
   assign hi_bound = lim_set_ff ? lim_ff.ext_lim : stroke_ff;
   assign span     = hi_bound - lo_bound;
   assign fcode_off = FOLLOW_CODE - `AMC_ADC_LO;
   assign prod     = span * fcode_off;

   // Linear map of follower code onto the active stroke
   always_comb
   begin
      if (FOLLOW_CODE <= `AMC_ADC_LO)
         follow_tgt = lo_bound;
      else if (FOLLOW_CODE >= `AMC_ADC_HI)
         follow_tgt = hi_bound;
      else
         follow_tgt = lo_bound + `AMC_POS_W'(prod / `AMC_ADC_SPAN);
   end

   always_comb
   begin
      nxt_target = target_ff;
      if (follow_en && FOLLOW_VALID)
         nxt_target = follow_tgt;
   end

   always_comb
   begin
      if (follow_en && !cmd_any)
      begin
         // Start only outside a small band, then run onto the target, so
         // steps still in the sync pipe cannot make the tube hunt
         want_ext = ({1'b0, pos_ff} + `AMC_FOLLOW_DB < {1'b0, target_ff}) ||
                    (drv_ff.fwd && target_ff > pos_ff);
         want_ret = ({1'b0, target_ff} + `AMC_FOLLOW_DB < {1'b0, pos_ff}) ||
                    (drv_ff.rev && target_ff < pos_ff);
      end
      else
      begin
         want_ext = cmd_ext;
         want_ret = cmd_ret;
      end
      if (pos_ff >= hi_bound)
         want_ext = 1'b0;
      if (pos_ff <= lo_bound)
         want_ret = 1'b0;
   end

   // Motion state: run, brake on withdrawal, sleep after idle time
   always_comb
   begin
      nxt_state = state_ff;
      nxt_idle  = idle_ff;
      nxt_drv   = '0;
      // Follower motion counts as activity, else it would sleep mid-move
      if (cmd_any || want_ext || want_ret)
         nxt_idle = 32'h0;
      else if (idle_ff < SLEEP_CYC)
         nxt_idle = idle_ff + 32'h1;
      unique case (state_ff)
         AMC_ST_RUN:
         begin
            nxt_drv.fwd = want_ext;
            nxt_drv.rev = want_ret;
            if (!want_ext && !want_ret)
               nxt_state = AMC_ST_BRAKE;
         end
         AMC_ST_BRAKE:
         begin
            nxt_drv.brake = 1'b1;
            if (want_ext || want_ret)
               nxt_state = AMC_ST_RUN;
            else if (!cmd_any && idle_ff >= SLEEP_CYC - 1)
               nxt_state = AMC_ST_SLEEP;
         end
         AMC_ST_SLEEP:
         begin
            nxt_drv.sleep = 1'b1;
            if (cmd_any || want_ext || want_ret)
            begin
               nxt_drv.sleep = 1'b0;
               nxt_state = AMC_ST_BRAKE;
            end
         end
         default: nxt_state = AMC_ST_BRAKE;
      endcase
   end

   // Position and stroke end tracking from the encoder
   always_comb
   begin
      nxt_pos = pos_ff;
      if (step_s && dir_s && pos_ff != `AMC_POS_MAX_RST)
         nxt_pos = pos_ff + `AMC_POS_W'(1);
      else if (step_s && !dir_s && pos_ff != `AMC_POS_MIN_RST)
         nxt_pos = pos_ff - `AMC_POS_W'(1);
      nxt_min = (pos_ff == `AMC_POS_MIN_RST);
      nxt_max = (pos_ff >= stroke_ff);
   end

   // One output pulse train, divided to the screw's travel per pulse
   always_comb
   begin
      nxt_pcnt  = pcnt_ff;
      nxt_pulse = 1'b0;
      if (step_s)
      begin
         if (pcnt_ff + 8'h01 >= div_ff)
         begin
            nxt_pcnt  = 8'h00;
            nxt_pulse = 1'b1;
         end
         else
            nxt_pcnt = pcnt_ff + 8'h01;
      end
   end

   // Limit programming by held inputs
   always_comb
   begin
      nxt_hold_key  = {pret_s, pext_s};
      nxt_hold      = hold_ff;
      nxt_hold_done = hold_done_ff;
      nxt_lim       = lim_ff;
      nxt_lim_set   = lim_set_ff;
      if (nxt_hold_key != hold_key_ff || !stationary || !follow_extreme)
      begin
         nxt_hold      = 32'h0;
         nxt_hold_done = 1'b0;
      end
      else if (nxt_hold_key != 2'b00 && !hold_done_ff)
      begin
         if (hold_ff >= PROG_CYC - 1)
         begin
            nxt_hold_done = 1'b1;
            unique case (nxt_hold_key)
               2'b11:
               begin
                  nxt_lim_set = 1'b0;
                  nxt_lim     = '0;
               end
               2'b01:
               begin
                  nxt_lim.ext_lim = pos_ff;
                  if (!lim_set_ff)
                     nxt_lim.ret_lim = `AMC_POS_MIN_RST;
                  nxt_lim_set = 1'b1;
               end
               2'b10:
               begin
                  nxt_lim.ret_lim = pos_ff;
                  if (!lim_set_ff)
                     nxt_lim.ext_lim = stroke_ff;
                  nxt_lim_set = 1'b1;
               end
               default: nxt_lim_set = lim_set_ff;
            endcase
         end
         else
            nxt_hold = hold_ff + 32'h1;
      end
   end

   // APB slave, zero wait states
   assign apb_wr = PSEL & PENABLE & PWRITE;
   assign apb_rd = PSEL & ~PENABLE & ~PWRITE;
   always_comb
   begin
      nxt_ctrl   = ctrl_ff;
      nxt_stroke = stroke_ff;
      nxt_div    = div_ff;
      nxt_rdata  = rdata_ff;
      nxt_err    = 1'b0;
      if (PSEL && !PENABLE)
      begin
         nxt_err = !(PADDR == `AMC_ADDR_CTRL || PADDR == `AMC_ADDR_STATUS ||
                     PADDR == `AMC_ADDR_POS  || PADDR == `AMC_ADDR_LIMITS ||
                     PADDR == `AMC_ADDR_FOLLOW ||
                     PADDR == `AMC_ADDR_STROKE);
         if (apb_rd)
         begin
            unique case (PADDR)
               `AMC_ADDR_CTRL:   nxt_rdata = ctrl_ff;
               `AMC_ADDR_STATUS: nxt_rdata = {23'h0, lim_set_ff, max_ff,
                                    min_ff, drv_ff, state_ff};
               `AMC_ADDR_POS:    nxt_rdata = {16'h0, pos_ff};
               `AMC_ADDR_LIMITS: nxt_rdata = lim_ff;
               `AMC_ADDR_FOLLOW: nxt_rdata = {16'h0, target_ff};
               `AMC_ADDR_STROKE: nxt_rdata = {16'h0, stroke_ff};
               default:          nxt_rdata = 32'h0;
            endcase
         end
      end
      if (apb_wr && !err_ff)
      begin
         if (PADDR == `AMC_ADDR_CTRL)
         begin
            nxt_ctrl = {23'h0, PWDATA[8:0]};
            nxt_div  = (PWDATA[15:8] == 8'h00) ? 8'h01 : PWDATA[15:8];
         end
         if (PADDR == `AMC_ADDR_STROKE)
            nxt_stroke = PWDATA[15:0];
      end
   end
   assign PRDATA  = rdata_ff;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & err_ff;

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         state_ff     <= AMC_ST_BRAKE;
         idle_ff      <= 32'h0;
         hold_ff      <= 32'h0;
         hold_key_ff  <= 2'b00;
         hold_done_ff <= 1'b0;
         pos_ff       <= `AMC_POS_MIN_RST;
         stroke_ff    <= `AMC_POS_MAX_RST;
         lim_ff       <= '0;
         lim_set_ff   <= 1'b0;
         target_ff    <= `AMC_POS_MIN_RST;
         div_ff       <= `AMC_PULSE_DIV_RST;
         pcnt_ff      <= 8'h00;
         pulse_ff     <= 1'b0;
         ctrl_ff      <= `AMC_CTRL_RST;
         rdata_ff     <= 32'h0;
         err_ff       <= 1'b0;
         drv_ff       <= '0;
         min_ff       <= 1'b0;
         max_ff       <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         idle_ff      <= nxt_idle;
         hold_ff      <= nxt_hold;
         hold_key_ff  <= nxt_hold_key;
         hold_done_ff <= nxt_hold_done;
         pos_ff       <= nxt_pos;
         stroke_ff    <= nxt_stroke;
         lim_ff       <= nxt_lim;
         lim_set_ff   <= nxt_lim_set;
         target_ff    <= nxt_target;
         div_ff       <= nxt_div;
         pcnt_ff      <= nxt_pcnt;
         pulse_ff     <= nxt_pulse;
         ctrl_ff      <= nxt_ctrl;
         rdata_ff     <= nxt_rdata;
         err_ff       <= nxt_err;
         drv_ff       <= nxt_drv;
         min_ff       <= nxt_min;
         max_ff       <= nxt_max;
      end
   end

   assign DRIVE             = drv_ff;
   assign MIN_STROKE_CLOSED = min_ff;
   assign MAX_STROKE_CLOSED = max_ff;
   assign PULSE_OUT         = pulse_ff;
endmodule

// ---- tb/amc_chk.sv ----
// Purpose: Port assertions for amc_top
// Assumes: Follower enable follows APB writes to CTRL bit 0
// Notes:   Margins allow two sync stages plus registered outputs
`timescale 1ns/1ns
`include "amc_defines.svh"
module amc_chk
#(
   parameter int unsigned SLEEP_CYC = 200
)
(
   input wire logic                CLK,
   input wire logic                RSTN,
   input wire logic                EXTEND_IN,
   input wire logic                RETRACT_IN,
   input wire logic                POS_STEP,
   input wire amc_pkg::amc_drive_s DRIVE,
   input wire logic                MIN_STROKE_CLOSED,
   input wire logic                MAX_STROKE_CLOSED,
   input wire logic                PULSE_OUT,
   input wire logic                PSEL,
   input wire logic                PENABLE,
   input wire logic                PWRITE,
   input wire logic [11:0]         PADDR,
   input wire logic [31:0]         PWDATA
);
   import amc_pkg::*;
   localparam int unsigned SLP_HI = SLEEP_CYC + 12;
   logic        fol_ff, nxt_fol;
   int unsigned idle_ff, nxt_idle;
   // The follower may move the tube on its own, so the stop, brake and late-sleep checks skip it
   always_comb
   begin
      nxt_fol = fol_ff;
      if (PSEL && PENABLE && PWRITE && PADDR == `AMC_ADDR_CTRL)
         nxt_fol = PWDATA[0];
      nxt_idle = (EXTEND_IN || RETRACT_IN) ? 0 : idle_ff + 1;
   end
   always_ff @(posedge CLK)
   begin
      fol_ff  <= RSTN ? nxt_fol : 1'b1;
      idle_ff <= RSTN ? nxt_idle : 0;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   sequence s_run;
      (DRIVE.fwd || DRIVE.rev) && !fol_ff;
   endsequence
   sequence s_quiet;
      (!EXTEND_IN && !RETRACT_IN && !fol_ff) [*5];
   endsequence
   property p_excl;
      !(DRIVE.fwd && DRIVE.rev);
   endproperty
   a_excl: assert property (p_excl) else $error("both directions");
   property p_both;
      (EXTEND_IN && RETRACT_IN) [*6] |-> !DRIVE.fwd && !DRIVE.rev;
   endproperty
   a_both: assert property (p_both) else $error("moves on both");
   property p_stop;
      (!EXTEND_IN && !RETRACT_IN && !fol_ff) [*6] |-> !DRIVE.fwd && !DRIVE.rev;
   endproperty
   a_stop: assert property (p_stop) else $error("moves idle");
   property p_brake;
      s_run ##1 s_quiet |-> DRIVE.brake;
   endproperty
   a_brake: assert property (p_brake) else $error("no brake");
   property p_slp_lo;
      $rose(DRIVE.sleep) |-> idle_ff >= SLEEP_CYC;
   endproperty
   a_slp_lo: assert property (p_slp_lo) else $error("early sleep");
   property p_slp_hi;
      idle_ff == SLP_HI && !fol_ff |-> DRIVE.sleep;
   endproperty
   a_slp_hi: assert property (p_slp_hi) else $error("no sleep");
   property p_wake;
      DRIVE.sleep && ($rose(EXTEND_IN) || $rose(RETRACT_IN))
         |-> ##[1:10] !DRIVE.sleep;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_ends;
      !(MIN_STROKE_CLOSED && MAX_STROKE_CLOSED);
   endproperty
   a_ends: assert property (p_ends) else $error("both ends");
   property p_pulse;
      PULSE_OUT |-> $past(POS_STEP) || $past(POS_STEP, 2)
         || $past(POS_STEP, 3) || $past(POS_STEP, 4);
   endproperty
   a_pulse: assert property (p_pulse) else $error("stray pulse");
endmodule

bind amc_top amc_chk #(.SLEEP_CYC(SLEEP_CYC)) u_chk (.CLK(CLK), .RSTN(RSTN),
   .EXTEND_IN(EXTEND_IN), .RETRACT_IN(RETRACT_IN), .POS_STEP(POS_STEP),
   .DRIVE(DRIVE), .MIN_STROKE_CLOSED(MIN_STROKE_CLOSED),
   .MAX_STROKE_CLOSED(MAX_STROKE_CLOSED), .PULSE_OUT(PULSE_OUT),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA));

// ---- tb/amc_user.sv ----
// Purpose: User side of amc_top: switches and encoder feedback
// Assumes: One step per cycle of motor drive, half rate when slow
// Notes:   Idle direction line toggles so a stale level is never trusted
`timescale 1ns/1ns
module amc_user
(
   input  wire logic                clk,
   input  wire amc_pkg::amc_drive_s drive,
   input  wire logic                slow,
   input  wire logic                ext_req,
   input  wire logic                ret_req,
   input  wire logic                pe_req,
   input  wire logic                pr_req,
   output logic                     ext_o = 1'b0,
   output logic                     ret_o = 1'b0,
   output logic                     pe_o = 1'b0,
   output logic                     pr_o = 1'b0,
   output logic                     step_o = 1'b0,
   output logic                     dir_o = 1'b0
);
   import amc_pkg::*;
   logic ph_ff = 1'b0;
   always @(posedge clk)
   begin
      ph_ff  <= slow ? !ph_ff : 1'b1;
      ext_o  <= ext_req;
      ret_o  <= ret_req;
      pe_o   <= pe_req;
      pr_o   <= pr_req;
      step_o <= (drive.fwd || drive.rev) && ph_ff;
      dir_o  <= (drive.fwd || drive.rev) ? drive.fwd : !dir_o;
   end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for amc_top
// Assumes: Short sleep and programming counts through parameters
// Notes:   Small stroke keeps every travel under two hundred cycles
`timescale 1ns/1ns
`include "amc_defines.svh"
module testbench;
   import amc_pkg::*;
   localparam int unsigned SLP = 200;
   localparam int unsigned PRG = 100;
   localparam logic [15:0] STK = 16'h0040;
   logic        CLK = 1'b0, RSTN = 1'b0, slow = 1'b0;
   logic        ext_req = 1'b0, ret_req = 1'b0, pe_req = 1'b0, pr_req = 1'b0;
   logic        EXTEND_IN, RETRACT_IN, PROG_EXT_IN, PROG_RET_IN;
   logic        POS_STEP, POS_DIR_EXT, PREADY, PSLVERR, er;
   logic        MIN_STROKE_CLOSED, MAX_STROKE_CLOSED, PULSE_OUT;
   logic        FOLLOW_VALID = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] FOLLOW_CODE = 12'h000, PADDR = 12'h000;
   logic [11:0] cl [3];
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, r;
   logic [31:0] seed = 32'hd1a11d0c;
   logic [15:0] p, q;
   amc_drive_s  DRIVE;
   int          failures = 0, n_compared = 0, npul = 0, i;
   always #50 CLK = ~CLK;
   amc_user u_user (.clk(CLK), .drive(DRIVE), .slow(slow), .ext_req(ext_req),
      .ret_req(ret_req), .pe_req(pe_req), .pr_req(pr_req), .ext_o(EXTEND_IN),
      .ret_o(RETRACT_IN), .pe_o(PROG_EXT_IN), .pr_o(PROG_RET_IN),
      .step_o(POS_STEP), .dir_o(POS_DIR_EXT));
   amc_top #(.SLEEP_CYC(SLP), .PROG_CYC(PRG)) dut (.CLK(CLK), .RSTN(RSTN),
      .EXTEND_IN(EXTEND_IN), .RETRACT_IN(RETRACT_IN),
      .PROG_EXT_IN(PROG_EXT_IN), .PROG_RET_IN(PROG_RET_IN),
      .FOLLOW_CODE(FOLLOW_CODE), .FOLLOW_VALID(FOLLOW_VALID),
      .POS_STEP(POS_STEP), .POS_DIR_EXT(POS_DIR_EXT), .DRIVE(DRIVE),
      .MIN_STROKE_CLOSED(MIN_STROKE_CLOSED), .PULSE_OUT(PULSE_OUT),
      .MAX_STROKE_CLOSED(MAX_STROKE_CLOSED), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR));
   always @(posedge CLK)
      if (PULSE_OUT === 1'b1) npul <= npul + 1;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] tgt(input logic [11:0] c);
      if (c <= `AMC_ADC_LO) return 16'h0;
      if (c >= `AMC_ADC_HI) return STK;
      return 16'((32'(c - `AMC_ADC_LO) * STK) / `AMC_ADC_SPAN);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      logic rdy;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
         rd = PRDATA;
         er = PSLVERR;
         rdy = PREADY;
      end
      while (rdy !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   // Keys held well past the count, since the device syncs them first
   task automatic prog(input logic e, input logic x);
      pe_req <= e;
      pr_req <= x;
      repeat (PRG + 20) @(posedge CLK);
      pe_req <= 1'b0;
      pr_req <= 1'b0;
      repeat (6) @(posedge CLK);
   endtask
   task automatic run(input logic e, input logic x, input int n);
      ext_req <= e;
      ret_req <= x;
      repeat (n) @(posedge CLK);
      ext_req <= 1'b0;
      ret_req <= 1'b0;
      repeat (12) @(posedge CLK);
      apb(0, `AMC_ADDR_POS, 0);
   endtask
   task automatic wrap_up();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #(100 * 20000);
      failures++;
      wrap_up();
   end
   initial
   begin
      repeat (4) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      apb(0, `AMC_ADDR_CTRL, 0);
      chk(rd[15:0], 16'h0101);
      apb(0, `AMC_ADDR_STROKE, 0);
      chk(rd[15:0], 16'hffff);
      apb(1, 12'h0f0, 32'h1);
      chk(16'(er), 16'h1);
      apb(1, `AMC_ADDR_STROKE, 32'(STK));
      apb(1, `AMC_ADDR_CTRL, 32'h100);
      r = rnd();
      slow <= r[0];
      $display("registers done");
      ext_req <= 1'b1;
      for (i = 0; i < 600 && MAX_STROKE_CLOSED !== 1'b1; i++) @(posedge CLK);
      repeat (12) @(posedge CLK);
      chk(16'(MAX_STROKE_CLOSED), 16'h1);
      chk(16'(MIN_STROKE_CLOSED), 16'h0);
      chk(16'(DRIVE.fwd), 16'h0);
      apb(0, `AMC_ADDR_POS, 0);
      chk(16'(npul), rd[15:0]);
      chk(16'(rd[15:0] >= STK && rd[15:0] <= STK + 8), 16'h1);
      ext_req <= 1'b0;
      repeat (8) @(posedge CLK);
      chk(16'(DRIVE.brake), 16'h1);
      ext_req <= 1'b1;
      ret_req <= 1'b1;
      repeat (10) @(posedge CLK);
      chk(16'(DRIVE.fwd || DRIVE.rev), 16'h0);
      chk(16'(DRIVE.brake), 16'h1);
      ext_req <= 1'b0;
      for (i = 0; i < 600 && MIN_STROKE_CLOSED !== 1'b1; i++) @(posedge CLK);
      repeat (12) @(posedge CLK);
      chk(16'(MIN_STROKE_CLOSED), 16'h1);
      chk(16'(DRIVE.rev), 16'h0);
      ret_req <= 1'b0;
      $display("stroke test done");
      repeat (SLP + 20) @(posedge CLK);
      chk(16'(DRIVE.sleep), 16'h1);
      r = rnd();
      ext_req <= 1'b1;
      repeat (10) @(posedge CLK);
      chk(16'(DRIVE.sleep), 16'h0);
      chk(16'(DRIVE.fwd), 16'h1);
      run(1, 0, 10 + int'(r[3:0]));
      p = rd[15:0];
      $display("sleep test done");
      FOLLOW_CODE <= 12'h800;
      prog(0, 1);
      apb(0, `AMC_ADDR_STATUS, 0);
      chk(16'(rd[8]), 16'h0);
      FOLLOW_CODE <= 12'h000;
      prog(1, 0);
      apb(0, `AMC_ADDR_LIMITS, 0);
      chk(rd[31:16], p);
      run(1, 0, 20);
      chk(rd[15:0], p);
      run(0, 1, 8);
      q = rd[15:0];
      // Retract limit stays below the extend limit
      prog(0, 1);
      apb(0, `AMC_ADDR_LIMITS, 0);
      chk(rd[15:0], q);
      run(0, 1, 30);
      chk(rd[15:0], q);
      prog(1, 1);
      apb(0, `AMC_ADDR_STATUS, 0);
      chk(16'(rd[8]), 16'h0);
      $display("limit test done");
      apb(1, `AMC_ADDR_CTRL, 32'h101);
      r = rnd();
      cl[0] = 12'hf00;
      cl[1] = 12'h100;
      cl[2] = 12'h300 + 12'(r[10:0]);
      for (i = 0; i < 3; i++)
      begin
         FOLLOW_CODE <= cl[i];
         FOLLOW_VALID <= 1'b1;
         @(posedge CLK);
         FOLLOW_VALID <= 1'b0;
         apb(0, `AMC_ADDR_FOLLOW, 0);
         chk(16'(rd[15:0] - tgt(cl[i]) + 16'h1 <= 16'h2), 16'h1);
         repeat (200) @(posedge CLK);
         chk(16'(MAX_STROKE_CLOSED), 16'(cl[i] >= `AMC_ADC_HI));
         chk(16'(MIN_STROKE_CLOSED), 16'(cl[i] <= `AMC_ADC_LO));
      end
      $display("follower test done");
      wrap_up();
   end
endmodule
